// ---- core/nipc_defs.vh ----
// Constants for the nested interrupt priority controller
`ifndef NIPC_DEFS_VH
`define NIPC_DEFS_VH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define NIPC_NSRC 8
`define NIPC_AW 8
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define NIPC_OFF_REQ 8'h00
`define NIPC_OFF_MASK 8'h04
`define NIPC_OFF_PRLO 8'h08
`define NIPC_OFF_PRHI 8'h0C
`define NIPC_OFF_PSW 8'h10
`define NIPC_OFF_STAT 8'h14
// ----------------------------------------
// Reset values
// ----------------------------------------
`define NIPC_RST_REQ 8'h00
`define NIPC_RST_MASK 8'hFF
`define NIPC_RST_PR 8'hFF
`define NIPC_RST_PSW 8'h06
// ----------------------------------------
// Status word field positions
// ----------------------------------------
`define NIPC_PSW_ACCEPT 7
`define NIPC_PSW_LVL_HI 2
`define NIPC_PSW_LVL_LO 1
`define NIPC_LVL_NONE 2'h3
`endif

// ---- core/nipc_ctrl.v ----
// Nested interrupt priority controller with register port and sequencer handshake
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "nipc_defs.vh"

// What this block does
// - No maskable acknowledge while the accept flag in the status word is clear.
// - Any acknowledge clears the accept flag.
// - The accept-on instruction sets the accept flag.
// - Accept flag set: a level above the in-service level is acknowledged; level 0 also nests on level 0.
// - A level below the in-service level is not acknowledged.
// - Refused requests stay pending and are taken once acceptable.
// - After a return marked hold-type, one program instruction completes before any maskable acknowledge.
// - Nesting compares programmed levels, never the fixed source order.
// - Source level is the high and low priority bit pair; 00 highest, 11 lowest.
// - In-service bits 00 mean level 0 or 1, 01 level 2, 10 level 3.
// - In-service bits 11 mean idle; every level is acceptable with the flag set.
// - Software break always taken; every level is then acceptable until a maskable acknowledge or return from break.
// - Hold-type instructions defer acknowledge until the next instruction completes.
// - Writes to request, mask or priority registers defer acknowledge likewise.
// - A source is a candidate only with request set and mask clear.
// - Acknowledging level code not 00 loads in-service bits with code minus one.
// - Best level wins; ties go to the higher fixed order (lower index).
// - Reset loads the status word with in-service bits set, flag clear.
module nipc_ctrl (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Register port
  input wire [`NIPC_AW-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Peripheral request events
  input wire [`NIPC_NSRC-1:0] req_set_i,
  // Instruction sequencer
  input wire instr_done_i,
  input wire instr_hold_i,
  input wire accept_on_instruction_i,
  input wire accept_off_instruction_i,
  input wire soft_break_i,
  input wire return_from_vectored_i,
  input wire return_from_break_i,
  input wire [7:0] psw_restore_i,
  // Acknowledge to sequencer
  output reg ack_o,
  output reg ack_soft_o,
  output reg [2:0] ack_src_o,
  output reg [7:0] psw_saved_o,
  output reg [7:0] program_status_word_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Level of one source from its high and low priority bits
  function [1:0] src_level;
    input [7:0] hi;
    input [7:0] lo;
    input [2:0] idx;
    begin
      src_level = {hi[idx], lo[idx]};
    end
  endfunction

  // In-service bits to load for an acknowledged level
  function [1:0] lvl_to_isp;
    input [1:0] lvl;
    begin
      if (lvl == 2'h0) begin
        lvl_to_isp = 2'h0;
      end else begin
        lvl_to_isp = lvl - 2'h1;
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] request_flag_bank_a;
  reg [7:0] mask_flag_bank_a;
  reg [7:0] priority_low_bits_bank_a;
  reg [7:0] priority_high_bits_bank_a;
  reg soft_active;
  reg defer;
  reg wr_hold;

  wire maskable_accept_flag;
  wire in_service_level_high;
  wire in_service_level_low;
  wire [1:0] isp;
  wire wr_req;
  wire wr_mask;
  wire wr_prlo;
  wire wr_prhi;
  wire wr_psw;
  wire hold_now;
  wire boundary;

  assign maskable_accept_flag = program_status_word_o[`NIPC_PSW_ACCEPT];
  assign in_service_level_high = program_status_word_o[`NIPC_PSW_LVL_HI];
  assign in_service_level_low = program_status_word_o[`NIPC_PSW_LVL_LO];
  assign isp = {in_service_level_high, in_service_level_low};
  assign wr_req = reg_wr_i && (reg_addr_i == `NIPC_OFF_REQ);
  assign wr_mask = reg_wr_i && (reg_addr_i == `NIPC_OFF_MASK);
  assign wr_prlo = reg_wr_i && (reg_addr_i == `NIPC_OFF_PRLO);
  assign wr_prhi = reg_wr_i && (reg_addr_i == `NIPC_OFF_PRHI);
  assign wr_psw = reg_wr_i && (reg_addr_i == `NIPC_OFF_PSW);

  // Completing instruction defers the next decision
  assign hold_now = instr_hold_i | wr_hold | wr_req | wr_mask | wr_prlo | wr_prhi | wr_psw;
  // Decision point: a completed instruction not itself deferred
  assign boundary = instr_done_i && !defer && !hold_now;

  // ----------------------------------------
  // Candidate selection
  // ----------------------------------------
  reg found;
  reg [2:0] best_idx;
  reg [1:0] best_lvl;
  reg [1:0] lvl;
  integer i;

  // Lowest level code wins, lower index wins ties
  // Sources are scanned from index 0 upward, so a tie keeps the earliest source
  always @* begin
    found = 1'b0;
    best_idx = 3'h0;
    best_lvl = `NIPC_LVL_NONE;
    lvl = 2'h0;
    for (i = 0; i < `NIPC_NSRC; i = i + 1) begin
      lvl = src_level(priority_high_bits_bank_a, priority_low_bits_bank_a, i[2:0]);
      if (request_flag_bank_a[i] && !mask_flag_bank_a[i]) begin
        if (!found || (lvl < best_lvl)) begin
          found = 1'b1;
          best_idx = i[2:0];
          best_lvl = lvl;
        end
      end
    end
  end

  // Acceptance of the best candidate
  // The in-service code sits one below the running level, so a level code at or
  // below it is strictly higher priority, except level 0, which may nest on itself;
  // one plain code compare covers both cases and the idle code 11 takes every level
  reg take_mask;
  always @* begin
    take_mask = 1'b0;
    if (found && maskable_accept_flag) begin
      if (soft_active) begin
        take_mask = 1'b1;
      end else if (best_lvl <= isp) begin
        take_mask = 1'b1;
      end
    end
  end

  wire do_soft;
  wire do_mask;
  assign do_soft = soft_break_i;
  assign do_mask = boundary && take_mask && !soft_break_i;

  // ----------------------------------------
  // Deferral tracking
  // ----------------------------------------

  // A register write marks its instruction as hold-type
  // The mark clears on the completion it belongs to; that completion sees it through
  // hold_now first, so the deferral is never lost when both fall in one cycle
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wr_hold <= 1'b0;
      defer <= 1'b0;
    end else begin
      if (instr_done_i) begin
        wr_hold <= 1'b0;
      end else if (wr_req | wr_mask | wr_prlo | wr_prhi | wr_psw) begin
        wr_hold <= 1'b1;
      end
      if (instr_done_i) begin
        defer <= hold_now;
      end
    end
  end

  // ----------------------------------------
  // Source registers
  // ----------------------------------------

  // Request flags: hardware set wins over software or acknowledge clear
  // A refused request is never cleared here, so it is taken at a later decision point
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      request_flag_bank_a <= `NIPC_RST_REQ;
    end else begin
      request_flag_bank_a <= (wr_req ? reg_wdata_i : request_flag_bank_a)
        & ~(do_mask ? (8'h01 << best_idx) : 8'h00)
        | req_set_i;
    end
  end

  // Mask and priority registers
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      mask_flag_bank_a <= `NIPC_RST_MASK;
      priority_low_bits_bank_a <= `NIPC_RST_PR;
      priority_high_bits_bank_a <= `NIPC_RST_PR;
    end else begin
      if (wr_mask) begin
        mask_flag_bank_a <= reg_wdata_i;
      end
      if (wr_prlo) begin
        priority_low_bits_bank_a <= reg_wdata_i;
      end
      if (wr_prhi) begin
        priority_high_bits_bank_a <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------

  // Return restore beats acknowledge, which beats instructions and writes
  // A return loads a whole saved word, so no flag update may be merged into it
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      program_status_word_o <= `NIPC_RST_PSW;
      soft_active <= 1'b0;
    end else begin
      if (return_from_vectored_i || return_from_break_i) begin
        program_status_word_o <= psw_restore_i;
      end else if (do_soft) begin
        program_status_word_o[`NIPC_PSW_ACCEPT] <= 1'b0;
      end else if (do_mask) begin
        program_status_word_o[`NIPC_PSW_ACCEPT] <= 1'b0;
        program_status_word_o[`NIPC_PSW_LVL_HI:`NIPC_PSW_LVL_LO] <= lvl_to_isp(best_lvl);
      end else if (accept_on_instruction_i) begin
        program_status_word_o[`NIPC_PSW_ACCEPT] <= 1'b1;
      end else if (accept_off_instruction_i) begin
        program_status_word_o[`NIPC_PSW_ACCEPT] <= 1'b0;
      end else if (wr_psw) begin
        program_status_word_o <= reg_wdata_i;
      end
      if (do_soft) begin
        soft_active <= 1'b1;
      end else if (do_mask || return_from_break_i) begin
        soft_active <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Acknowledge outputs
  // ----------------------------------------

  // One-cycle acknowledge with saved status word
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      ack_soft_o <= 1'b0;
      ack_src_o <= 3'h0;
      psw_saved_o <= 8'h00;
    end else begin
      ack_o <= do_soft | do_mask;
      ack_soft_o <= do_soft;
      if (do_mask) begin
        ack_src_o <= best_idx;
      end
      if (do_soft | do_mask) begin
        psw_saved_o <= program_status_word_o;
      end
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------

  // Read data stands in the cycle after the strobe only
  // The status byte shows the live decision inputs so software can see why a source waits
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `NIPC_OFF_REQ: reg_rdata_o <= request_flag_bank_a;
        `NIPC_OFF_MASK: reg_rdata_o <= mask_flag_bank_a;
        `NIPC_OFF_PRLO: reg_rdata_o <= priority_low_bits_bank_a;
        `NIPC_OFF_PRHI: reg_rdata_o <= priority_high_bits_bank_a;
        `NIPC_OFF_PSW: reg_rdata_o <= program_status_word_o;
        `NIPC_OFF_STAT: reg_rdata_o <= {4'h0, found, best_idx[2] & found, soft_active, defer};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

// ---- sim/nipc_seq_model.sv ----
// Sequencer model: step codes to pulses, saved status words on a stack
`timescale 1ns/1ps
module nipc_seq_model (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Step code and acknowledge
  input wire [2:0] op_i,
  input wire ack_o,
  input wire [7:0] psw_saved_o,
  // Sequencer outputs
  output wire instr_done_i,
  output wire instr_hold_i,
  output wire accept_on_instruction_i,
  output wire accept_off_instruction_i,
  output wire soft_break_i,
  output wire return_from_vectored_i,
  output wire return_from_break_i,
  output wire [7:0] psw_restore_i
);
  reg [7:0] stk [0:7];
  reg [2:0] sp;
  wire ret = op_i[2] && op_i[1];
  // Codes: 1 plain, 2 hold, 3 on, 4 off, 5 break, 6 and 7 returns
  assign instr_done_i = op_i != 3'd0 && op_i != 3'd5;
  assign instr_hold_i = op_i > 3'd1 && op_i != 3'd5;
  assign accept_on_instruction_i = op_i == 3'd3;
  assign accept_off_instruction_i = op_i == 3'd4;
  assign soft_break_i = op_i == 3'd5;
  assign return_from_vectored_i = op_i == 3'd6;
  assign return_from_break_i = op_i == 3'd7;
  // Outside a return the lines show the inverse, never a stale word
  assign psw_restore_i = ret ? stk[sp - 3'd1] : ~stk[sp - 3'd1];
  // Push on each acknowledge, pop on each return in a cycle without an acknowledge
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sp <= 3'd0;
    end else if (ack_o) begin
      stk[sp] <= psw_saved_o;
      sp <= sp + 3'd1;
    end else if (ret) begin
      sp <= sp - 3'd1;
    end
  end
endmodule

// ---- sim/nipc_ctrl_asserts.sv ----
// Port assertions for the priority controller
`timescale 1ns/1ps
module nipc_chk (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // Watched ports
  input wire instr_done_i,
  input wire instr_hold_i,
  input wire accept_on_instruction_i,
  input wire soft_break_i,
  input wire return_from_vectored_i,
  input wire return_from_break_i,
  input wire ack_o,
  input wire ack_soft_o,
  input wire [7:0] psw_saved_o,
  input wire [7:0] program_status_word_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire ret = return_from_vectored_i || return_from_break_i;
  wire dec = instr_done_i && !instr_hold_i;
  a_ack_cause: assert property (ack_o |-> $past(instr_done_i || soft_break_i))
    else $error("ack without cause");
  a_ack_clears: assert property (ack_o |-> !program_status_word_o[7])
    else $error("flag set after ack");
  a_flag_off: assert property (instr_done_i && !soft_break_i && !program_status_word_o[7] |=> !ack_o)
    else $error("ack with flag clear");
  a_break_taken: assert property (soft_break_i |=> ack_o && ack_soft_o)
    else $error("break not taken");
  a_hold_defer: assert property (instr_done_i && instr_hold_i ##1 instr_done_i && !soft_break_i |=> !ack_o)
    else $error("ack in hold window");
  a_lvl_loaded: assert property (ack_o && !ack_soft_o |-> program_status_word_o[2:1] != 2'h3)
    else $error("idle level after ack");
  a_saved_word: assert property (ack_o |-> psw_saved_o == $past(program_status_word_o))
    else $error("saved word wrong");
  a_on_sets: assert property (accept_on_instruction_i && !soft_break_i && !ret && !dec |=> program_status_word_o[7])
    else $error("flag not set");
  c_mask_ack: cover property (ack_o && !ack_soft_o);
  c_soft_ack: cover property (ack_soft_o);
  c_nested: cover property (ack_o && psw_saved_o[2:1] != 2'h3);
endmodule
bind nipc_ctrl nipc_chk u_nipc_chk (
  .ref_clk_i(ref_clk_i),
  .rst_b_i(rst_b_i),
  .instr_done_i(instr_done_i),
  .instr_hold_i(instr_hold_i),
  .accept_on_instruction_i(accept_on_instruction_i),
  .soft_break_i(soft_break_i),
  .return_from_vectored_i(return_from_vectored_i),
  .return_from_break_i(return_from_break_i),
  .ack_o(ack_o),
  .ack_soft_o(ack_soft_o),
  .psw_saved_o(psw_saved_o),
  .program_status_word_o(program_status_word_o)
);

// ---- sim/testbench.sv ----
// Self-checking bench for the priority controller
`timescale 1ns/1ps
`include "nipc_defs.vh"
module testbench;
  reg ref_clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg [7:0] req_set_i = 8'h00;
  reg [2:0] op = 3'd0;
  wire instr_done_i, instr_hold_i, accept_on_instruction_i, accept_off_instruction_i;
  wire soft_break_i, return_from_vectored_i, return_from_break_i, ack_o, ack_soft_o;
  wire [7:0] psw_restore_i, reg_rdata_o, psw_saved_o, program_status_word_o;
  wire [2:0] ack_src_o;
  integer failures = 0;
  integer n_compared = 0;
  nipc_ctrl u_nipc_ctrl (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .req_set_i(req_set_i),
    .instr_done_i(instr_done_i),
    .instr_hold_i(instr_hold_i),
    .accept_on_instruction_i(accept_on_instruction_i),
    .accept_off_instruction_i(accept_off_instruction_i),
    .soft_break_i(soft_break_i),
    .return_from_vectored_i(return_from_vectored_i),
    .return_from_break_i(return_from_break_i),
    .psw_restore_i(psw_restore_i),
    .ack_o(ack_o),
    .ack_soft_o(ack_soft_o),
    .ack_src_o(ack_src_o),
    .psw_saved_o(psw_saved_o),
    .program_status_word_o(program_status_word_o)
  );
  nipc_seq_model u_nipc_seq_model (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .op_i(op),
    .ack_o(ack_o),
    .psw_saved_o(psw_saved_o),
    .instr_done_i(instr_done_i),
    .instr_hold_i(instr_hold_i),
    .accept_on_instruction_i(accept_on_instruction_i),
    .accept_off_instruction_i(accept_off_instruction_i),
    .soft_break_i(soft_break_i),
    .return_from_vectored_i(return_from_vectored_i),
    .return_from_break_i(return_from_break_i),
    .psw_restore_i(psw_restore_i)
  );
  // Clock
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Compare and count
  task cmp(input string nm, input [7:0] e, s);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("unexpected %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // One strobe cycle; read data checked in the cycle after
  task bus(input w, input [7:0] a, d);
    begin
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= w;
      reg_rd_i <= !w;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1;
      if (!w) cmp("rdata", d, reg_rdata_o);
    end
  endtask
  // One sequencer step, then the pair {soft, ack}
  task step(input [2:0] o, input [7:0] r, input [1:0] ea);
    begin
      op <= o;
      req_set_i <= r;
      @(posedge ref_clk_i);
      op <= 3'd0;
      req_set_i <= 8'h00;
      #1 cmp("ack", {6'h0, ea}, {6'h0, ack_soft_o, ack_o});
    end
  endtask
  task nx;
    begin
      step(3'd1, 8'h00, 2'h0);
    end
  endtask
  // Accept on, then one deferred instruction
  task en;
    begin
      step(3'd3, 8'h00, 2'h0);
      nx;
    end
  endtask
  task ak(input [7:0] s, p);
    begin
      step(3'd1, 8'h00, 2'h1);
      cmp("src", s, {5'h0, ack_src_o});
      cmp("psw", p, program_status_word_o);
    end
  endtask
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // Scenarios; levels by source 0..7: 3 0 1 2 3 3 2 3
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    #1;
    bus(1'b0, `NIPC_OFF_PSW, 8'h06);
    bus(1'b0, 8'h18, 8'h00);
    bus(1'b1, `NIPC_OFF_PRLO, 8'hB5);
    bus(1'b1, `NIPC_OFF_PRHI, 8'hF9);
    bus(1'b1, `NIPC_OFF_MASK, 8'h00);
    bus(1'b0, `NIPC_OFF_PRHI, 8'hF9);
    nx;
    nx;
    step(3'd0, 8'h08, 2'h0);
    bus(1'b0, `NIPC_OFF_REQ, 8'h08);
    en;
    step(3'd4, 8'h00, 2'h0);
    nx;
    nx;
    en;
    bus(1'b1, `NIPC_OFF_MASK, 8'h00);
    nx;
    nx;
    ak(8'h03, 8'h02);
    cmp("saved", 8'h86, psw_saved_o);
    en;
    step(3'd0, 8'h20, 2'h0);
    nx;
    step(3'd0, 8'h40, 2'h0);
    nx;
    step(3'd0, 8'h04, 2'h0);
    ak(8'h02, 8'h00);
    nx;
    step(3'd6, 8'h00, 2'h0);
    cmp("psw", 8'h82, program_status_word_o);
    nx;
    step(3'd6, 8'h00, 2'h0);
    nx;
    ak(8'h06, 8'h02);
    nx;
    step(3'd6, 8'h00, 2'h0);
    nx;
    ak(8'h05, 8'h04);
    bus(1'b1, `NIPC_OFF_MASK, 8'h02);
    step(3'd0, 8'h06, 2'h0);
    en;
    ak(8'h02, 8'h00);
    bus(1'b1, `NIPC_OFF_MASK, 8'h00);
    en;
    ak(8'h01, 8'h00);
    en;
    step(3'd5, 8'h00, 2'h3);
    cmp("psw", 8'h00, program_status_word_o);
    step(3'd0, 8'h80, 2'h0);
    en;
    ak(8'h07, 8'h04);
    step(3'd0, 8'h49, 2'h0);
    en;
    ak(8'h03, 8'h02);
    nx;
    step(3'd7, 8'h02, 2'h0);
    cmp("psw", 8'h84, program_status_word_o);
    nx;
    bus(1'b1, `NIPC_OFF_PSW, 8'h86);
    nx;
    nx;
    ak(8'h01, 8'h00);
    conclude;
  end
endmodule
